// *** logic/fdc_defs.svh ***
/*
 * Control word layout and opcode constants for the filter datapath control word decoder.
 * Assumes it is included by the package, the datapath module, the sequencer model and the test bench.
 */
`ifndef FDC_DEFS_SVH
`define FDC_DEFS_SVH

// Control word size and field positions (lsb) and widths
`define FDC_CW_W 32
`define FDC_MUX_A_LSB 0
`define FDC_MUX_B_LSB 3
`define FDC_MUX_W 3
`define FDC_RAM_RW_LSB 6
`define FDC_RAM_RW_W 2
`define FDC_BUS_WR_BIT 8
`define FDC_ALU_LSB 9
`define FDC_ALU_W 5
`define FDC_MAC_LSB 14
`define FDC_MAC_W 2
`define FDC_SHIFT_LSB 16
`define FDC_SHIFT_W 3
`define FDC_ACU_LSB 19
`define FDC_ACU_W 8
`define FDC_ACU_ADDR_LSB 27
`define FDC_ACU_ADDR_W 4
`define FDC_EOB_BIT 31

// Mux code bits: bit0 picks feedback, bit1 picks RAM, bit2 picks MAC
`define FDC_MUX1_BIT 0
`define FDC_MUX2_BIT 1
`define FDC_MUX3_BIT 2

// Side-effect field width and the address bit that steers shared opcode 17
`define FDC_SEL_W 3
`define FDC_OP17_SEL_BIT 3

// ALU opcodes
`define FDC_OP_ZERO 5'h00
`define FDC_OP_ONE 5'h01
`define FDC_OP_PASSA 5'h02
`define FDC_OP_PASSB 5'h03
`define FDC_OP_NEGA 5'h04
`define FDC_OP_NEGB 5'h05
`define FDC_OP_RAMA 5'h06
`define FDC_OP_RAMB 5'h07
`define FDC_OP_ADD 5'h08
`define FDC_OP_TDEC 5'h09
`define FDC_OP_BSUBA 5'h0A
`define FDC_OP_ASUBB 5'h0B
`define FDC_OP_ABSA 5'h0C
`define FDC_OP_ABSB 5'h0D
`define FDC_OP_ABSA_ADD 5'h0E
`define FDC_OP_ABSB_ADD 5'h0F
`define FDC_OP_HOLD 5'h10
`define FDC_OP_EVT_EN 5'h11
`define FDC_OP_SEM_EN 5'h12
`define FDC_OP_SEM_RAISE 5'h13
`define FDC_OP_SEM_LOWER 5'h14
`define FDC_OP_T_BSUBA 5'h15
`define FDC_OP_T_ASUBB 5'h16
`define FDC_OP_T_ABSA_ADD 5'h17
`define FDC_OP_T_ABSB_ADD 5'h18
`define FDC_OP_SQ_THR 5'h19
`define FDC_OP_SQ_CNT 5'h1A
`define FDC_OP_SQ_A 5'h1B
`define FDC_OP_SQ_B 5'h1C

// Reset values
`define FDC_SEL_RST 3'h0

`endif

// *** logic/fdc_pkg.sv ***
/*
 * Types shared by the filter datapath control word decoder.
 * Assumes fdc_defs.svh is on the include path.
 */
`include "fdc_defs.svh"

package fdc_pkg;

   // Decoded control word fields
   typedef struct packed {
      logic eob;
      logic [`FDC_ACU_ADDR_W-1:0] acu_addr;
      logic [`FDC_ACU_W-1:0] acu_ctrl;
      logic [`FDC_SHIFT_W-1:0] shift_ctrl;
      logic [`FDC_MAC_W-1:0] mac_ctrl;
      logic [`FDC_ALU_W-1:0] alu_op;
      logic bus_wr;
      logic [`FDC_RAM_RW_W-1:0] ram_rw;
      logic [`FDC_MUX_W-1:0] mux_b;
      logic [`FDC_MUX_W-1:0] mux_a;
   } fdc_cw_t;

   // Enable and semaphore state kept by the ALU side effects
   typedef struct packed {
      logic [`FDC_SEL_W-1:0] jump_event_en;
      logic [`FDC_SEL_W-1:0] sat_round_en;
      logic [`FDC_SEL_W-1:0] sem_jump_en;
      logic [`FDC_SEL_W-1:0] sem;
   } fdc_flags_t;

endpackage : fdc_pkg

// *** logic/fdc_datapath.sv ***
/*
 * Filter engine datapath control word decoder: A/B source muxes, ALU,
 * semaphores, enable fields, squelch registers and holding registers.
 * Assumes the sequencer presents one control word per clk_sys cycle and that
 * bus data, RAM, MAC and feedback inputs come from logic on the same clock.
 */
// Operation
// - One 32-bit word per instruction, all fields
// - Mux field split into A and B codes
// - Three-bit shifter field passed on
// - Eight-bit ACU control, four-bit ACU address
// - End-of-block flag for the sequencer
// - Five-bit field selects ALU operation
// - Two-bit field selects MAC operation
// - First mux: bus even, feedback odd
// - Second mux RAM, third mux MAC
// - Opcodes 0-7: constants, pass, negate, RAM
// - Add, subtract, absolute and absolute sums
// - Decrement and threshold opcodes arm detection
// - Opcode 16 holds previous ALU output
// - Opcode 17 with addr bit 3 clear loads jump event enables
// - Opcode 17 with addr bit 3 set loads saturation/rounding enables instead
// - Opcode 18 loads semaphore jump enables
// - Opcode 19 raises masked semaphores
// - Opcode 20 lowers semaphores masked by addr
// - Opcode 25 loads squelch threshold, passes B
// - Opcode 26 loads squelch count, passes B
// - Opcodes 27/28 squelch side A or B
// - Semaphore ops follow low ACU address bits
// - Bus write fills holding A or B
`timescale 1ns/10ps
`include "fdc_defs.svh"

module fdc_datapath #(
   parameter int DW = 24                   // Datapath word width
) (
   input wire logic clk_sys,                  // 10 MHz datapath clock
   input wire logic rst_n,                    // Synchronous reset, active low
   input wire logic [`FDC_CW_W-1:0] ctrl_word, // Control word from control store
   input wire logic [DW-1:0] bus_data,         // System bus data
   input wire logic [DW-1:0] datapath_feedback, // Datapath output fed back
   input wire logic [DW-1:0] ram_a_out,         // Data RAM A output
   input wire logic [DW-1:0] ram_b_out,         // Data RAM B output
   input wire logic [DW-1:0] mac_a_result,      // MAC result, A path
   input wire logic [DW-1:0] mac_b_result,      // MAC result, B path
   output fdc_pkg::fdc_cw_t cw_reg,             // Registered decoded word
   output logic [DW-1:0] alu_out_reg,           // ALU output register
   output fdc_pkg::fdc_flags_t flags_reg,       // Enables and semaphores
   output logic thresh_arm_reg,                 // Threshold detection armed
   output logic thresh_hit_reg,                 // Armed result was negative
   output logic [DW-1:0] sq_thr_reg,            // Squelch threshold
   output logic [DW-1:0] sq_cnt_reg,            // Squelch count
   output logic [DW-1:0] hold_a_reg,            // Holding register A
   output logic [DW-1:0] hold_b_reg             // Holding register B
);
   import fdc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Field decode

   fdc_cw_t cw;
   logic [DW-1:0] a_val;
   logic [DW-1:0] b_val;
   logic [DW-1:0] alu_next;
   logic arm_next;
   logic [`FDC_SEL_W-1:0] mask;

   assign cw = fdc_cw_t'(ctrl_word);
   // mask taken from low ACU address bits
   assign mask = cw.acu_addr[`FDC_SEL_W-1:0];

   ////////////////////////////////////////////////////////////////////////
   // Source muxes, one function shared by both paths

   // mux1 bus or feedback; mux2/mux3 RAM and MAC
   function automatic logic [DW-1:0] path_sel(
      input logic [`FDC_MUX_W-1:0] code,
      input logic [DW-1:0] bus,
      input logic [DW-1:0] fb,
      input logic [DW-1:0] ram,
      input logic [DW-1:0] mac
   );
      logic [DW-1:0] m1;
      logic [DW-1:0] m2;
      m1 = code[`FDC_MUX1_BIT] ? fb : bus;
      m2 = code[`FDC_MUX2_BIT] ? ram : m1;
      return code[`FDC_MUX3_BIT] ? mac : m2;
   endfunction : path_sel

   // each path decoded from its own code
   // combinational, same cycle as the word
   assign a_val = path_sel(cw.mux_a, bus_data, datapath_feedback, ram_a_out, mac_a_result);
   assign b_val = path_sel(cw.mux_b, bus_data, datapath_feedback, ram_b_out, mac_b_result);

   ////////////////////////////////////////////////////////////////////////
   // ALU function

   function automatic logic [DW-1:0] absv(input logic [DW-1:0] v);
      return v[DW-1] ? DW'(-v) : v;
   endfunction : absv

   // Squelch: small magnitudes go to zero only once the count is spent
   function automatic logic [DW-1:0] squelch(
      input logic [DW-1:0] v,
      input logic [DW-1:0] thr,
      input logic [DW-1:0] cnt
   );
      if (absv(v) < thr && cnt == '0) begin
         return '0;
      end
      return v;
   endfunction : squelch

   // ALU result and arming decode; undefined codes fall to hold
   // five-bit opcode picks the operation
   always_comb begin
      alu_next = alu_out_reg;
      arm_next = 1'b0;
      case (cw.alu_op)
         `FDC_OP_ZERO: alu_next = '0;
         `FDC_OP_ONE: alu_next = DW'(1);
         `FDC_OP_PASSA: alu_next = a_val;
         `FDC_OP_PASSB: alu_next = b_val;
         `FDC_OP_NEGA: alu_next = DW'(-a_val);
         `FDC_OP_NEGB: alu_next = DW'(-b_val);
         `FDC_OP_RAMA: alu_next = ram_a_out;
         `FDC_OP_RAMB: alu_next = ram_b_out;
         `FDC_OP_ADD: alu_next = DW'(a_val + b_val);
         `FDC_OP_BSUBA: alu_next = DW'(b_val - a_val);
         `FDC_OP_ASUBB: alu_next = DW'(a_val - b_val);
         `FDC_OP_ABSA: alu_next = absv(a_val);
         `FDC_OP_ABSB: alu_next = absv(b_val);
         `FDC_OP_ABSA_ADD: alu_next = DW'(absv(a_val) + b_val);
         `FDC_OP_ABSB_ADD: alu_next = DW'(a_val + absv(b_val));
         `FDC_OP_TDEC: begin
            alu_next = DW'(a_val - DW'(1));
            arm_next = 1'b1;
         end
         `FDC_OP_T_BSUBA: begin
            alu_next = DW'(b_val - a_val);
            arm_next = 1'b1;
         end
         `FDC_OP_T_ASUBB: begin
            alu_next = DW'(a_val - b_val);
            arm_next = 1'b1;
         end
         `FDC_OP_T_ABSA_ADD: begin
            alu_next = DW'(absv(a_val) + b_val);
            arm_next = 1'b1;
         end
         `FDC_OP_T_ABSB_ADD: begin
            alu_next = DW'(a_val + absv(b_val));
            arm_next = 1'b1;
         end
         `FDC_OP_SQ_THR: alu_next = b_val;
         `FDC_OP_SQ_CNT: alu_next = b_val;
         `FDC_OP_SQ_A: alu_next = squelch(a_val, sq_thr_reg, sq_cnt_reg);
         `FDC_OP_SQ_B: alu_next = squelch(b_val, sq_thr_reg, sq_cnt_reg);
         default: alu_next = alu_out_reg;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   // ALU output register
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         alu_out_reg <= '0;
      end else begin
         alu_out_reg <= alu_next;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         thresh_arm_reg <= 1'b0;
         thresh_hit_reg <= 1'b0;
      end else begin
         thresh_arm_reg <= arm_next;
         thresh_hit_reg <= arm_next & alu_next[DW-1];
      end
   end

   // fields handed on
   // Registered so downstream units see the word with the ALU result
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cw_reg <= '0;
      end else begin
         cw_reg <= cw;
      end
   end

   // Enables and semaphores in one process, so flags_reg has one driver
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         flags_reg.jump_event_en <= `FDC_SEL_RST;
         flags_reg.sat_round_en <= `FDC_SEL_RST;
         flags_reg.sem_jump_en <= `FDC_SEL_RST;
         flags_reg.sem <= `FDC_SEL_RST;
      end else begin
         // shared code split by address bit 3
         if (cw.alu_op == `FDC_OP_EVT_EN) begin
            if (cw.acu_addr[`FDC_OP17_SEL_BIT]) begin
               flags_reg.sat_round_en <= mask;
            end else begin
               flags_reg.jump_event_en <= mask;
            end
         end
         if (cw.alu_op == `FDC_OP_SEM_EN) begin
            flags_reg.sem_jump_en <= mask;
         end
         // Semaphores: only masked bits move
         // raise masked bits
         if (cw.alu_op == `FDC_OP_SEM_RAISE) begin
            flags_reg.sem <= flags_reg.sem | mask;
         end
         if (cw.alu_op == `FDC_OP_SEM_LOWER) begin
            flags_reg.sem <= flags_reg.sem & ~mask;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sq_thr_reg <= '0;
         sq_cnt_reg <= '0;
      end else begin
         if (cw.alu_op == `FDC_OP_SQ_THR) begin
            sq_thr_reg <= a_val;
         end
         if (cw.alu_op == `FDC_OP_SQ_CNT) begin
            sq_cnt_reg <= a_val;
         end
      end
   end

   // holding registers from the datapath output
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         hold_a_reg <= '0;
         hold_b_reg <= '0;
      end else if (cw.bus_wr) begin
         if (cw.acu_addr[0]) begin
            hold_b_reg <= datapath_feedback;
         end else begin
            hold_a_reg <= datapath_feedback;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_op(logic [`FDC_ALU_W-1:0] op);
      cw.alu_op == op;
   endsequence

   sequence s_hold_any;
      cw.alu_op == `FDC_OP_HOLD || cw.alu_op > `FDC_OP_SQ_B;
   endsequence

   a_pass_a_value: assert property (s_op(`FDC_OP_PASSA) |=>
      alu_out_reg == $past(a_val))
      else $error("pass A result wrong");

   a_mux_bus_even: assert property (cw.mux_a == 3'h0 |-> a_val == bus_data)
      else $error("A path code 0 not bus data");

   a_mux_mac_hi: assert property (cw.mux_b[2] |-> b_val == mac_b_result)
      else $error("B path high code not MAC");

   a_add_sum: assert property (s_op(`FDC_OP_ADD) |=>
      alu_out_reg == DW'($past(a_val) + $past(b_val)))
      else $error("add result wrong");

   a_hold_keeps: assert property (s_hold_any |=> $stable(alu_out_reg))
      else $error("hold changed ALU output");

   a_hold_no_sem: assert property (s_hold_any |=> $stable(flags_reg))
      else $error("undefined opcode touched flags");

   a_arm_tdec: assert property (s_op(`FDC_OP_TDEC) |=>
      thresh_arm_reg && alu_out_reg == DW'($past(a_val) - DW'(1)))
      else $error("decrement did not arm");

   a_sem_raise: assert property (s_op(`FDC_OP_SEM_RAISE) ##0 (mask != 3'h0) |=>
      (flags_reg.sem & $past(mask)) == $past(mask))
      else $error("semaphore not raised");

   a_sem_lower: assert property (s_op(`FDC_OP_SEM_LOWER) |=>
      (flags_reg.sem & $past(mask)) == 3'h0
      ##1 ((flags_reg.sem & $past(mask, 2)) == 3'h0 || cw_reg.alu_op == `FDC_OP_SEM_RAISE))
      else $error("semaphore not lowered");

   a_sem_enable: assert property (s_op(`FDC_OP_SEM_EN) |=>
      flags_reg.sem_jump_en == $past(mask))
      else $error("semaphore enable not loaded");

   a_op17_split: assert property (s_op(`FDC_OP_EVT_EN) ##0 cw.acu_addr[3] |=>
      flags_reg.sat_round_en == $past(mask) && $stable(flags_reg.jump_event_en))
      else $error("opcode 17 split wrong");

   a_sq_thr_load: assert property (s_op(`FDC_OP_SQ_THR) |=>
      sq_thr_reg == $past(a_val) && alu_out_reg == $past(b_val))
      else $error("squelch threshold load wrong");

   a_hold_reg_b: assert property (cw.bus_wr && cw.acu_addr[0] |=>
      hold_b_reg == $past(datapath_feedback) && $stable(hold_a_reg))
      else $error("holding B not written");

   a_ram_a_direct: assert property (s_op(`FDC_OP_RAMA) |=>
      alu_out_reg == $past(ram_a_out))
      else $error("RAM A pass result wrong");

   a_mux_fb_odd: assert property (cw.mux_b == 3'h1 |-> b_val == datapath_feedback)
      else $error("B path code 1 not feedback");

   a_arm_quiet: assert property (!(cw.alu_op == `FDC_OP_TDEC ||
      (cw.alu_op >= `FDC_OP_T_BSUBA && cw.alu_op <= `FDC_OP_T_ABSB_ADD)) |=>
      !thresh_arm_reg && !thresh_hit_reg)
      else $error("threshold armed by other opcode");

   a_evt_load: assert property (s_op(`FDC_OP_EVT_EN) ##0 !cw.acu_addr[3] |=>
      flags_reg.jump_event_en == $past(mask) && $stable(flags_reg.sat_round_en))
      else $error("jump event enable not loaded");

   a_sq_cnt_load: assert property (s_op(`FDC_OP_SQ_CNT) |=>
      sq_cnt_reg == $past(a_val) && alu_out_reg == $past(b_val))
      else $error("squelch count load wrong");

   a_squelch_zero: assert property (s_op(`FDC_OP_SQ_A) ##0
      (absv(a_val) < sq_thr_reg && sq_cnt_reg == '0) |=> alu_out_reg == '0)
      else $error("small A not squelched");

   a_squelch_pass: assert property (s_op(`FDC_OP_SQ_B) ##0 sq_cnt_reg != '0 |=>
      alu_out_reg == $past(b_val))
      else $error("B not passed with count set");

   a_hold_reg_a: assert property (cw.bus_wr && !cw.acu_addr[0] |=>
      hold_a_reg == $past(datapath_feedback) && $stable(hold_b_reg))
      else $error("holding A not written");

endmodule : fdc_datapath

// *** verification/fdc_seq_model.sv ***
/*
 * Sequencer and system bus stand-in: presents one control word and fresh
 * source data on every falling edge of clk_sys.
 * Assumes the bench may pin the control word through fix_en and fix_cw.
 */
`timescale 1ns/10ps
`include "fdc_defs.svh"

module fdc_seq_model #(
   parameter int DW = 24 // Datapath word width
) (
   input wire logic clk_sys, // Datapath clock
   input wire logic fix_en, // Use fix_cw instead of a random word
   input wire logic [`FDC_CW_W-1:0] fix_cw, // Pinned control word
   output logic [`FDC_CW_W-1:0] ctrl_word, // Word to the datapath
   output logic [DW-1:0] bus_data, // System bus data
   output logic [DW-1:0] datapath_feedback, // Feedback value
   output logic [DW-1:0] ram_a_out, // RAM A output
   output logic [DW-1:0] ram_b_out, // RAM B output
   output logic [DW-1:0] mac_a_result, // MAC A result
   output logic [DW-1:0] mac_b_result // MAC B result
);
   int seed = 32'hC568;

   // Half the values are tiny so squelch compares and zero counts occur
   function logic [DW-1:0] rnd_val();
      logic [31:0] r;
      r = $random(seed);
      return r[0] ? {{(DW-4){1'b0}}, r[7:4]} : r[31:32-DW];
   endfunction : rnd_val

   initial begin
      ctrl_word = '0;
      {bus_data, datapath_feedback, ram_a_out, ram_b_out} = '0;
      {mac_a_result, mac_b_result} = '0;
   end

   //////////////////////////////////////////////////////////////////////
   // New word every cycle
   always @(negedge clk_sys) begin
      ctrl_word <= fix_en ? fix_cw : $random(seed);
      bus_data <= rnd_val();
      datapath_feedback <= rnd_val();
      ram_a_out <= rnd_val();
      ram_b_out <= rnd_val();
      mac_a_result <= rnd_val();
      mac_b_result <= rnd_val();
   end
endmodule : fdc_seq_model

// *** verification/fdc_datapath_test.sv ***
/*
 * Self-checking bench for fdc_datapath: random words from the sequencer
 * model plus pinned corner words, checked against a cycle model.
 * Assumes fdc_pkg and fdc_defs.svh are compiled and on the include path.
 */
`timescale 1ns/10ps
`include "fdc_defs.svh"

module fdc_datapath_test;
   import fdc_pkg::*;
   localparam int DW = 24;
   logic clk_sys;
   logic rst_n;
   logic fix_en;
   logic chk_on;
   logic [`FDC_CW_W-1:0] fix_cw;
   logic [`FDC_CW_W-1:0] ctrl_word;
   logic [DW-1:0] bus_data, datapath_feedback, ram_a_out, ram_b_out;
   logic [DW-1:0] mac_a_result, mac_b_result;
   fdc_cw_t cw_reg, e_cw;
   fdc_flags_t flags_reg, e_flags;
   logic [DW-1:0] alu_out_reg, sq_thr_reg, sq_cnt_reg, hold_a_reg, hold_b_reg;
   logic [DW-1:0] e_alu, e_thr, e_cnt, e_ha, e_hb;
   logic thresh_arm_reg, thresh_hit_reg, e_arm, e_hit;
   int miscompares = 0;
   int total_checks = 0;

   fdc_seq_model #(.DW(DW)) seq (.clk_sys(clk_sys), .fix_en(fix_en), .fix_cw(fix_cw),
      .ctrl_word(ctrl_word), .bus_data(bus_data), .datapath_feedback(datapath_feedback),
      .ram_a_out(ram_a_out), .ram_b_out(ram_b_out), .mac_a_result(mac_a_result),
      .mac_b_result(mac_b_result));

   fdc_datapath #(.DW(DW)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .ctrl_word(ctrl_word),
      .bus_data(bus_data), .datapath_feedback(datapath_feedback), .ram_a_out(ram_a_out),
      .ram_b_out(ram_b_out), .mac_a_result(mac_a_result), .mac_b_result(mac_b_result),
      .cw_reg(cw_reg), .alu_out_reg(alu_out_reg), .flags_reg(flags_reg),
      .thresh_arm_reg(thresh_arm_reg), .thresh_hit_reg(thresh_hit_reg),
      .sq_thr_reg(sq_thr_reg), .sq_cnt_reg(sq_cnt_reg), .hold_a_reg(hold_a_reg),
      .hold_b_reg(hold_b_reg));

   //////////////////////////////////////////////////////////////////////
   // 10 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Source select: feedback on bit 0, RAM over it, MAC over both
   function automatic logic [DW-1:0] pick(input logic [2:0] c, input logic [DW-1:0] bus,
                                          input logic [DW-1:0] fb, input logic [DW-1:0] ram,
                                          input logic [DW-1:0] mac);
      logic [DW-1:0] v;
      v = c[0] ? fb : bus;
      if (c[1]) v = ram;
      if (c[2]) v = mac;
      return v;
   endfunction : pick

   function automatic logic [DW-1:0] mag(input logic [DW-1:0] v);
      return v[DW-1] ? -v : v;
   endfunction : mag

   function automatic logic [DW-1:0] squelch(input logic [DW-1:0] v);
      return (mag(v) < e_thr && e_cnt == '0) ? '0 : v;
   endfunction : squelch

   function automatic fdc_cw_t mk(input logic [4:0] op, input logic [3:0] ad,
                                  input logic [2:0] ma, input logic [2:0] mb, input logic bw);
      fdc_cw_t w;
      w = '0;
      w.alu_op = op;
      w.acu_addr = ad;
      w.mux_a = ma;
      w.mux_b = mb;
      w.bus_wr = bw;
      return w;
   endfunction : mk

   // Pinned words: hold from reset, semaphores, enables, undefined ops, muxes
   function automatic fdc_cw_t corner(input int i);
      case (i)
         0: return mk(`FDC_OP_HOLD, 4'h0, 3'h0, 3'h0, 1'b0);
         1: return mk(`FDC_OP_SEM_RAISE, 4'h7, 3'h0, 3'h0, 1'b0);
         2: return mk(`FDC_OP_SEM_LOWER, 4'h5, 3'h0, 3'h0, 1'b0);
         3, 4, 5: return mk(5'h1D + i[4:0] - 5'h03, 4'hF, 3'h1, 3'h2, 1'b0);
         6: return mk(`FDC_OP_EVT_EN, 4'hF, 3'h0, 3'h0, 1'b0);
         7: return mk(`FDC_OP_EVT_EN, 4'h6, 3'h0, 3'h0, 1'b0);
         8: return mk(`FDC_OP_SEM_EN, 4'h3, 3'h0, 3'h0, 1'b0);
         9: return mk(`FDC_OP_SEM_RAISE, 4'h8, 3'h0, 3'h0, 1'b0);
         10: return mk(`FDC_OP_ADD, 4'h0, 3'h0, 3'h0, 1'b1);
         11: return mk(`FDC_OP_ADD, 4'h1, 3'h0, 3'h0, 1'b1);
         28: return mk(`FDC_OP_SQ_CNT, 4'h0, 3'h0, 3'h0, 1'b0);
         29: return mk(`FDC_OP_SQ_A, 4'h0, 3'h0, 3'h0, 1'b0);
         default: return (i < 20) ? mk(`FDC_OP_PASSA, 4'h0, 3'(i - 12), 3'h0, 1'b0)
                                  : mk(`FDC_OP_PASSB, 4'h0, 3'h0, 3'(i - 20), 1'b0);
      endcase
   endfunction : corner

   //////////////////////////////////////////////////////////////////////
   // Cycle model of every registered output
   always @(posedge clk_sys) begin
      fdc_cw_t cw;
      logic [DW-1:0] a, b;
      cw = ctrl_word;
      a = pick(cw.mux_a, bus_data, datapath_feedback, ram_a_out, mac_a_result);
      b = pick(cw.mux_b, bus_data, datapath_feedback, ram_b_out, mac_b_result);
      if (!rst_n) begin
         {e_cw, e_flags, e_alu, e_thr, e_cnt, e_ha, e_hb, e_arm, e_hit} = '0;
      end else begin
         e_cw = cw;
         if (cw.bus_wr && cw.acu_addr[0]) e_hb = datapath_feedback;
         if (cw.bus_wr && !cw.acu_addr[0]) e_ha = datapath_feedback;
         case (cw.alu_op)
            `FDC_OP_ZERO: e_alu = '0;
            `FDC_OP_ONE: e_alu = 1;
            `FDC_OP_PASSA: e_alu = a;
            `FDC_OP_PASSB: e_alu = b;
            `FDC_OP_NEGA: e_alu = -a;
            `FDC_OP_NEGB: e_alu = -b;
            `FDC_OP_RAMA: e_alu = ram_a_out;
            `FDC_OP_RAMB: e_alu = ram_b_out;
            `FDC_OP_ADD: e_alu = a + b;
            `FDC_OP_TDEC: e_alu = a - 1;
            `FDC_OP_BSUBA, `FDC_OP_T_BSUBA: e_alu = b - a;
            `FDC_OP_ASUBB, `FDC_OP_T_ASUBB: e_alu = a - b;
            `FDC_OP_ABSA: e_alu = mag(a);
            `FDC_OP_ABSB: e_alu = mag(b);
            `FDC_OP_ABSA_ADD, `FDC_OP_T_ABSA_ADD: e_alu = mag(a) + b;
            `FDC_OP_ABSB_ADD, `FDC_OP_T_ABSB_ADD: e_alu = a + mag(b);
            `FDC_OP_EVT_EN: begin
               if (cw.acu_addr[3]) e_flags.sat_round_en = cw.acu_addr[2:0];
               else e_flags.jump_event_en = cw.acu_addr[2:0];
            end
            `FDC_OP_SEM_EN: e_flags.sem_jump_en = cw.acu_addr[2:0];
            `FDC_OP_SEM_RAISE: e_flags.sem = e_flags.sem | cw.acu_addr[2:0];
            `FDC_OP_SEM_LOWER: e_flags.sem = e_flags.sem & ~cw.acu_addr[2:0];
            `FDC_OP_SQ_A: e_alu = squelch(a);
            `FDC_OP_SQ_B: e_alu = squelch(b);
            default: ;
         endcase
         if (cw.alu_op == `FDC_OP_SQ_THR) {e_thr, e_alu} = {a, b};
         if (cw.alu_op == `FDC_OP_SQ_CNT) {e_cnt, e_alu} = {a, b};
         e_arm = cw.alu_op == `FDC_OP_TDEC || (cw.alu_op >= `FDC_OP_T_BSUBA &&
                 cw.alu_op <= `FDC_OP_T_ABSB_ADD);
         e_hit = e_arm && e_alu[DW-1];
      end
   end

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic final_report();
      $display("Checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report

   //////////////////////////////////////////////////////////////////////
   // outputs against the cycle model
   always @(negedge clk_sys) begin
      if (chk_on) begin
         check(cw_reg[15:0], e_cw[15:0]);
         check(cw_reg[31:16], e_cw[31:16]);
         check(alu_out_reg, e_alu);
         if (e_cw.alu_op == `FDC_OP_PASSA || e_cw.alu_op == `FDC_OP_PASSB) begin
            check(alu_out_reg, e_alu);
         end
         check(flags_reg[11:6], e_flags[11:6]);
         check(flags_reg[5:0], e_flags[5:0]);
         check({thresh_arm_reg, thresh_hit_reg}, {e_arm, e_hit});
         check(sq_thr_reg, e_thr);
         check(sq_cnt_reg, e_cnt);
         check(hold_a_reg, e_ha);
         check(hold_b_reg, e_hb);
      end
   end

   // Watchdog: the run needs about 3340 cycles
   initial begin
      #500000;
      miscompares++;
      final_report();
   end

   // Reset, corner words, random traffic, a mid-run reset, more traffic
   initial begin
      rst_n = 1'b0;
      // Hold word pinned through reset so the first word after release is hold
      fix_en = 1'b1;
      fix_cw = corner(0);
      chk_on = 1'b0;
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_n <= 1'b1;
      @(negedge clk_sys);
      chk_on <= 1'b1;
      for (int i = 1; i < 30; i++) begin
         fix_cw <= corner(i);
         @(negedge clk_sys);
      end
      fix_en <= 1'b0;
      repeat (3000) @(negedge clk_sys);
      rst_n <= 1'b0;
      repeat (2) @(negedge clk_sys);
      rst_n <= 1'b1;
      repeat (300) @(negedge clk_sys);
      final_report();
   end
endmodule : fdc_datapath_test
